// file: core/ips_core.v
// Interrupt entry logic with page stack and first extended enable register.
// Assumes requests are level signals on pclk and the core pulses its return.
// Assumes software keeps nothing in the bottom stack level across interrupts.
`timescale 1ns/100ps
`default_nettype none
`include "ips_consts.vh"
// Contract
// - A pending high-priority request preempts a running low-priority routine once core_ready is high.
// - On vectoring, the active page selector takes the serviced source's page.
// - On entry, the old active page is pushed into the middle stack level.
// - On entry, the old middle level is pushed into the bottom level.
// - Entry overwrites any value software wrote into the bottom level.
// - Enable bit 7 masks the first converter end-of-conversion request.
module ips_core #(
	parameter N = 8,
	parameter W = 3,
	parameter [8*N-1:0] SRC_PAGES = {8'h00, 8'h01, 8'h02, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00}
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [9:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [N-1:0] src_req,
	input wire core_ready,
	input wire core_reti,
	output reg vec_valid,
	output reg [W-1:0] vec_index,
	output reg vec_high,
	output reg [7:0] active_page_selector,
	output wire irq
);
	// Software-visible state
	reg [7:0] extended_irq_enable_one;
	reg [7:0] page_stack_middle;
	reg [7:0] page_stack_bottom;
	reg [7:0] prio_high;
	reg [2:0] status;
	reg [2:0] mask;
	// Nesting state of the core
	reg [1:0] level; // 0 idle, 1 low active, 2 high active
	reg [1:0] next_level;
	reg low_nested;
	// Request masking and the two priority pickers
	wire [N-1:0] en_req;
	wire [N-1:0] hi_req;
	wire lo_found, hi_found;
	wire [W-1:0] lo_idx, hi_idx;
	// Bus strobes
	wire wr, rd;
	wire wr_page, wr_middle, wr_bottom, wr_ext_en, wr_prio, wr_mask, wr_status;
	wire [2:0] status_clr;
	// Arbitration result for this cycle
	reg take, take_hi;
	reg [W-1:0] take_idx;
	reg [2:0] ev;

	// Single-cycle access, no wait states
	assign pready = 1'b1;
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	// Unmapped offsets answer with an error instead of stalling the bus
	assign pslverr = psel & penable & ~decode_hit(paddr);

	// Write strobes, one per register but the read-only level, high in the access cycle only
	assign wr_page = wr & (paddr == `IPS_ADDR_PAGE);
	assign wr_middle = wr & (paddr == `IPS_ADDR_MIDDLE);
	assign wr_bottom = wr & (paddr == `IPS_ADDR_BOTTOM);
	assign wr_ext_en = wr & (paddr == `IPS_ADDR_EXT_EN);
	assign wr_prio = wr & (paddr == `IPS_ADDR_PRIO);
	assign wr_mask = wr & (paddr == `IPS_ADDR_MASK);
	assign wr_status = wr & (paddr == `IPS_ADDR_STATUS);
	// Write-one-to-clear bits for the status register
	assign status_clr = wr_status ? pwdata[2:0] : 3'b000;

	// True for any mapped register offset
	function decode_hit;
		input [9:0] a;
		begin
			decode_hit = (a == `IPS_ADDR_EXT_EN) || (a == `IPS_ADDR_PAGE) || (a == `IPS_ADDR_MIDDLE) ||
				(a == `IPS_ADDR_BOTTOM) || (a == `IPS_ADDR_STATUS) || (a == `IPS_ADDR_MASK) ||
				(a == `IPS_ADDR_PRIO) || (a == `IPS_ADDR_LEVEL);
		end
	endfunction

	// A masked request stays pending at its source until it is enabled
	// conv0 mask
	assign en_req = src_req & extended_irq_enable_one;
	assign hi_req = en_req & prio_high;

	// The high picker sees only high-priority requests; the low picker sees
	// every enabled one and is used only while nothing is running
	ips_prio_pick #(.N(N), .W(W)) u_hi (.req(hi_req), .found(hi_found), .idx(hi_idx));
	ips_prio_pick #(.N(N), .W(W)) u_lo (.req(en_req), .found(lo_found), .idx(lo_idx));

	// Arbitration: high wins; a high request may interrupt a low routine
	// A return is served before any new entry, so a pop is never lost and
	// the stack never moves twice in one cycle
	always @* begin
		take = 1'b0;
		take_hi = 1'b0;
		take_idx = {W{1'b0}};
		next_level = level;
		ev = 3'b000;
		if (core_reti && level != 2'd0) begin
			// Leaving high returns to low only if it had preempted one
			next_level = (level == 2'd2 && low_nested) ? 2'd1 : 2'd0;
			ev[`IPS_ST_RETURN] = 1'b1;
		end else if (core_ready && hi_found && level != 2'd2) begin
			take = 1'b1;
			take_hi = 1'b1;
			take_idx = hi_idx;
			next_level = 2'd2;
			ev[`IPS_ST_ENTRY] = 1'b1;
			ev[`IPS_ST_PREEMPT] = (level == 2'd1);
		end else if (core_ready && lo_found && level == 2'd0) begin
			// Low entries start only from idle; a running low routine blocks them
			take = 1'b1;
			take_idx = lo_idx;
			next_level = 2'd1;
			ev[`IPS_ST_ENTRY] = 1'b1;
		end
	end

	// Vector, level and page stack
	// The bottom level is overwritten on every entry, so a value kept there
	// by software does not survive an interrupt
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level <= 2'd0;
			low_nested <= 1'b0;
			vec_valid <= 1'b0;
			vec_index <= {W{1'b0}};
			vec_high <= 1'b0;
			active_page_selector <= `IPS_PAGE_RESET;
			page_stack_middle <= 8'h00;
			page_stack_bottom <= 8'h00;
		end else begin
			level <= next_level;
			vec_valid <= take;
			if (take) begin
				vec_index <= take_idx;
				vec_high <= take_hi;
				low_nested <= (level == 2'd1);
				active_page_selector <= SRC_PAGES[8*take_idx +: 8];
				page_stack_middle <= active_page_selector;
				page_stack_bottom <= page_stack_middle;
			end else if (ev[`IPS_ST_RETURN]) begin
				active_page_selector <= page_stack_middle;
				page_stack_middle <= page_stack_bottom;
				if (level == 2'd2)
					low_nested <= 1'b0;
			end else if (wr) begin
				// Software writes lose to hardware stack moves
				if (wr_page)
					active_page_selector <= pwdata[7:0];
				if (wr_middle)
					page_stack_middle <= pwdata[7:0];
				if (wr_bottom)
					page_stack_bottom <= pwdata[7:0];
			end
		end
	end

	// Software registers; status set wins over write-one-to-clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			extended_irq_enable_one <= `IPS_EXT_EN_RESET;
			prio_high <= 8'h00;
			mask <= 3'b000;
			status <= 3'b000;
		end else begin
			if (wr_ext_en)
				extended_irq_enable_one <= pwdata[7:0];
			if (wr_prio)
				prio_high <= pwdata[7:0];
			if (wr_mask)
				mask <= pwdata[2:0];
			// An event in the cycle of a clear is kept, so no entry goes unseen
			status <= (status & ~status_clr) | ev;
		end
	end

	// Level interrupt, high while any unmasked status bit is set
	assign irq = |(status & mask);

	// Read data captured in the setup cycle, valid in the access cycle
	// Reads have no side effects, so a repeated read is harmless
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd) begin
			case (paddr)
				`IPS_ADDR_EXT_EN: prdata <= {24'h000000, extended_irq_enable_one};
				`IPS_ADDR_PAGE: prdata <= {24'h000000, active_page_selector};
				`IPS_ADDR_MIDDLE: prdata <= {24'h000000, page_stack_middle};
				`IPS_ADDR_BOTTOM: prdata <= {24'h000000, page_stack_bottom};
				`IPS_ADDR_STATUS: prdata <= {29'h00000000, status};
				`IPS_ADDR_MASK: prdata <= {29'h00000000, mask};
				`IPS_ADDR_PRIO: prdata <= {24'h000000, prio_high};
				`IPS_ADDR_LEVEL: prdata <= {30'h00000000, level};
				default: prdata <= 32'h00000000;
			endcase
		end
	end
endmodule // ips_core
`default_nettype wire

// file: pkg/ips_consts.vh
// Constants for the interrupt page stack block.
// Assumes inclusion by bare name from design files.
`ifndef IPS_CONSTS_VH
`define IPS_CONSTS_VH
// APB byte addresses
// Enable register index; its byte address is four times the index
`define IPS_EXT_EN_INDEX 8'hE6
`define IPS_ADDR_EXT_EN 10'h398
`define IPS_ADDR_PAGE 10'h000
`define IPS_ADDR_MIDDLE 10'h004
`define IPS_ADDR_BOTTOM 10'h008
`define IPS_ADDR_STATUS 10'h00C
`define IPS_ADDR_MASK 10'h010
`define IPS_ADDR_PRIO 10'h014
`define IPS_ADDR_LEVEL 10'h018
// Reset values
`define IPS_EXT_EN_RESET 8'h00
`define IPS_PAGE_RESET 8'h00
// Enable bit positions
`define IPS_BIT_CONV0 7
`define IPS_BIT_CMP2 6
// Status bits for the summary interrupt
`define IPS_ST_ENTRY 0
`define IPS_ST_PREEMPT 1
`define IPS_ST_RETURN 2
`endif

// file: core/ips_prio_pick.v
// Priority picker: lowest-index pending request wins within a mask.
// Assumes request and mask come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module ips_prio_pick #(
	parameter N = 8,
	parameter W = 3
) (
	input wire [N-1:0] req,
	output reg found,
	output reg [W-1:0] idx
);
	integer i;
	// Scan downward so the lowest index is kept last
	always @* begin
		found = 1'b0;
		idx = {W{1'b0}};
		for (i = N - 1; i >= 0; i = i - 1) begin
			if (req[i]) begin
				found = 1'b1;
				idx = i[W-1:0];
			end
		end
	end
endmodule // ips_prio_pick
`default_nettype wire

// file: verification/ips_core_props.sv
// Checker on the ips_core ports.
// Assumes a bind from the bench top.
`timescale 1ns/100ps
`default_nettype none
`include "ips_consts.vh"
module ips_props #(parameter N = 8, parameter W = 3, parameter [8*N-1:0] SRC_PAGES = 0) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic core_ready,
	input wire logic core_reti,
	input wire logic vec_valid,
	input wire logic [W-1:0] vec_index,
	input wire logic vec_high,
	input wire logic [7:0] active_page_selector
);
	wire [7:0] pg = active_page_selector;
	wire wr = psel && penable && pwrite;
	reg [7:0] en;
	// Enable copy, so masking is judged from the ports alone
	always @(posedge pclk or negedge presetn)
		if (!presetn) en <= 8'h00;
		else if (wr && paddr == `IPS_ADDR_EXT_EN) en <= pwdata[7:0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_load; vec_valid |-> pg == SRC_PAGES[8*vec_index +: 8]; endproperty
	a_load: assert property (p_load) else $error("page not loaded");
	property p_pop; vec_valid && core_reti |=> pg == $past(pg, 2); endproperty
	a_pop: assert property (p_pop) else $error("page not restored");
	property p_cv; vec_valid && vec_index == 7 |-> $past(en[7]); endproperty
	a_cv: assert property (p_cv) else $error("masked conversion taken");
	property p_cmp; vec_valid && vec_index == 6 |-> $past(en[6]); endproperty
	a_cmp: assert property (p_cmp) else $error("masked comparator taken");
	property p_rdy; vec_valid |-> $past(core_ready); endproperty
	a_rdy: assert property (p_rdy) else $error("vector without ready core");
	property p_top; vec_valid && vec_high |=> !vec_valid; endproperty
	a_top: assert property (p_top) else $error("high routine preempted");
	property p_hold; !vec_valid |-> $stable(vec_index) && $stable(vec_high); endproperty
	a_hold: assert property (p_hold) else $error("vector result moved");
	property p_page; $changed(pg) |-> vec_valid || $past(core_reti || wr); endproperty
	a_page: assert property (p_page) else $error("page moved alone");
endmodule // ips_props
`default_nettype wire

// file: verification/ips_partner.sv
// Model of the core and the request sources.
// Assumes the bench pulses raise and ret for one cycle.
`timescale 1ns/100ps
`default_nettype none
module ips_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] raise,
	input wire logic ret,
	input wire logic quick,
	input wire logic stall,
	input wire logic vec_valid,
	input wire logic [2:0] vec_index,
	output logic [7:0] src_req,
	output wire logic core_ready,
	output wire logic core_reti
);
	logic r;
	// A source drops its flag once the core vectors to it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_req <= 8'h00;
			r <= 1'h0;
		end else begin
			src_req <= (src_req | raise) & ~({7'h00, vec_valid} << vec_index);
			r <= ret;
		end
	end
	// Quick mode returns in the entry cycle, the tightest case
	assign core_reti = r | (quick & vec_valid);
	// A busy core refuses vectors while stall is high
	assign core_ready = ~stall;
endmodule // ips_partner
`default_nettype wire

// file: verification/interrupt_page_stack_tb.sv
// Bench for the page stack: APB tasks and entry scenarios.
// Assumes a 100 MHz pclk and the partner model.
`timescale 1ns/100ps
`default_nettype none
`include "ips_consts.vh"
module interrupt_page_stack_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ret = 0, quick = 0, stall = 0, e;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [7:0] raise = 8'h00, src_req, page;
	logic pready, pslverr, core_ready, core_reti, vec_valid, vec_high, irq;
	logic [2:0] vec_index;
	int fails = 0, checks_done = 0, nv = 0;
	always #5 pclk = ~pclk;
	always @(posedge pclk) if (vec_valid === 1'h1) nv <= nv + 1;
	ips_core #(.SRC_PAGES({8'h02, 8'h01, 48'h0})) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_req(src_req), .core_ready(core_ready),
		.core_reti(core_reti), .vec_valid(vec_valid), .vec_index(vec_index), .vec_high(vec_high),
		.active_page_selector(page), .irq(irq));
	ips_partner pm (.pclk(pclk), .presetn(presetn), .raise(raise), .ret(ret), .quick(quick), .stall(stall),
		.vec_valid(vec_valid), .vec_index(vec_index), .src_req(src_req), .core_ready(core_ready),
		.core_reti(core_reti));
	task chk(input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, s, x);
		end
	endtask
	task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task rd(input logic [9:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		chk(q, x);
	endtask
	task src(input logic [7:0] b);
		@(posedge pclk);
		raise <= b;
		ret <= (b == 8'h00);
		@(posedge pclk);
		raise <= 8'h00;
		ret <= 1'h0;
	endtask
	task vec(input logic [2:0] i, input logic h, input logic [7:0] p);
		int n;
		n = 0;
		@(posedge pclk);
		while (vec_valid !== 1'h1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		chk({vec_valid, vec_index, vec_high, page}, {1'h1, i, h, p});
	endtask
	task print_verdict;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#20000;
		fails++;
		print_verdict;
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		rd(`IPS_ADDR_EXT_EN, 32'h0);
		apb(1'h1, `IPS_ADDR_PAGE, 32'h0F);
		apb(1'h1, `IPS_ADDR_BOTTOM, 32'h55);
		apb(1'h1, `IPS_ADDR_PRIO, 32'h08);
		apb(1'h1, `IPS_ADDR_MASK, 32'h01);
		src(8'hC0);
		repeat (5) @(posedge pclk);
		chk(nv, 32'h0);
		apb(1'h1, `IPS_ADDR_EXT_EN, 32'h88);
		vec(3'h7, 1'h0, 8'h02);
		rd(`IPS_ADDR_BOTTOM, 32'h00);
		chk(irq, 1'h1);
		src(8'h08);
		vec(3'h3, 1'h1, 8'h00);
		rd(`IPS_ADDR_LEVEL, 32'h02);
		rd(`IPS_ADDR_MIDDLE, 32'h02);
		rd(`IPS_ADDR_BOTTOM, 32'h0F);
		src(8'h00);
		src(8'h00);
		rd(`IPS_ADDR_PAGE, 32'h0F);
		apb(1'h1, `IPS_ADDR_STATUS, 32'h07);
		@(posedge pclk);
		chk(irq, 1'h0);
		$display("stack test done");
		stall <= 1'h1;
		apb(1'h1, `IPS_ADDR_EXT_EN, 32'hC8);
		repeat (3) @(posedge pclk);
		chk(nv, 32'h2);
		stall <= 1'h0;
		vec(3'h6, 1'h0, 8'h01);
		src(8'h00);
		quick <= 1'h1;
		src(8'h08);
		vec(3'h3, 1'h1, 8'h00);
		rd(`IPS_ADDR_PAGE, 32'h0F);
		apb(1'h0, 10'h3FC, 32'h0);
		chk(e, 1'h1);
		chk(pready, 1'h1);
		$display("mask test done");
		print_verdict;
	end
endmodule // interrupt_page_stack_tb
bind ips_core ips_props #(.N(N), .W(W), .SRC_PAGES(SRC_PAGES)) u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.core_ready(core_ready), .core_reti(core_reti), .vec_valid(vec_valid), .vec_index(vec_index),
	.vec_high(vec_high), .active_page_selector(active_page_selector));
`default_nettype wire
